/* File: rtl/gcm_clk_monitor.v */
`timescale 1ns/1ps
`include "gcm_map.vh"

// ************************************************************
// one monitored input: edge pulses and stuck / recovery flag
// ************************************************************
module gcm_clk_monitor (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       clk_level,
  output wire       rise,
  output wire       fall,
  output wire       bad
);

  localparam integer STUCK_CYC = `GCM_STUCK_CYC;
  localparam [31:0]  STUCK_W   = STUCK_CYC - 1;
  localparam [7:0]   STUCK_LIM = STUCK_W[7:0];

  reg        smp_ff;
  reg        prv_ff;
  reg  [7:0] idle_ff;
  reg  [2:0] rec_ff;
  reg        bad_ff;

  // the aclk itself is the free-running reference, so the timer
  // keeps counting while both monitored inputs are stopped
  assign rise = smp_ff & ~prv_ff;
  assign fall = ~smp_ff & prv_ff;
  assign bad  = bad_ff;

  // sample, idle timer, recovery counter
  always @(posedge aclk) begin
    if (!aresetn) begin
      // track the pin in reset, so release shows no false edge
      smp_ff  <= clk_level;
      prv_ff  <= smp_ff;
      idle_ff <= 8'h00;
      rec_ff  <= 3'h0;
      bad_ff  <= 1'b0;
    end else begin
      smp_ff <= clk_level;
      prv_ff <= smp_ff;
      if (rise || fall) begin
        idle_ff <= 8'h00;
      end else if (idle_ff != STUCK_LIM) begin
        idle_ff <= idle_ff + 8'h01; // see RQ20
      end
      // stuck detection wins over a clear in the same cycle
      if (!(rise || fall) && idle_ff == STUCK_LIM) begin
        bad_ff <= 1'b1; // see RQ7
        rec_ff <= 3'h0;
      end else if (bad_ff && rise) begin
        // fifth rise closes four whole periods
        if (rec_ff + 3'h1 == `GCM_RECOVER_RISES) begin
          bad_ff <= 1'b0; // see RQ8
          rec_ff <= 3'h0;
        end else begin
          rec_ff <= rec_ff + 3'h1;
        end
      end
    end
  end

endmodule // gcm_clk_monitor

/* File: rtl/gcm_clock_mux.v */
// Operation
// RQ1: mux switches cleanly between both inputs, running or stopped.
// RQ2: on select change outputs go low after one output cycle.
// RQ3: outputs stay low one new-input cycle, then follow it.
// RQ4: divide change finishes current cycle, then continues at new ratio.
// RQ5: disabled output completes its period before high impedance.
// RQ6: enabled output first drives low, then starts on clean rise.
// RQ7: stuck input over about 200ns sets its bad flag.
// RQ8: bad flag clears after four full periods of restored input.
// RQ9: while selected input is bad, outputs are held low.
// RQ10: select moved to good input: low one period, then run.
// RQ11: divide change while bad takes effect when clock returns.
// RQ12: disable while input bad goes to high impedance at once.
// RQ13: re-enable after recovery drives low before first rise.
// RQ14: changes during stuck detection wait until bad flag sets.
// RQ15: deferred change: low on bad, follow new clock's second period.
// RQ16: deferred transitions are glitch free, may take up to 1us.
// RQ17: select high picks second input, low picks first input.
// RQ18: each bank divides by one or two on its own select.
// RQ19: each output has active-high enable, default enabled.
// RQ20: stuck timeout uses free-running reference independent of inputs.
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "gcm_map.vh"

module gcm_clock_mux (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        first_input_pair,
  input  wire        second_input_pair,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [3:0]  bank_a_clock_outputs,
  output wire [3:0]  bank_a_oe,
  output wire [3:0]  bank_b_clock_outputs,
  output wire [3:0]  bank_b_oe
);

  // ************************************************************
  // states of the switch sequencer
  // ************************************************************
  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_DRAIN = 2'h1;
  localparam [1:0] ST_HOLD  = 2'h2;

  // ************************************************************
  // declarations
  // ************************************************************
  reg  [11:0] ctrl_ff;
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg         cur_sel_ff;
  reg         nxt_cur_sel;
  reg         seen_ff;
  reg         nxt_seen;
  reg  [1:0]  level_ff;
  reg  [1:0]  nxt_level;
  reg  [1:0]  ratio_ff;
  reg  [1:0]  nxt_ratio;
  reg  [1:0]  frz_ff;
  reg  [1:0]  nxt_frz;
  reg  [1:0]  bnd;
  reg  [7:0]  oe_ff;
  reg  [7:0]  nxt_oe;
  reg  [7:0]  live_ff;
  reg  [7:0]  nxt_live;
  reg  [7:0]  q_ff;
  reg  [7:0]  nxt_q;
  reg  [1:0]  req_ratio;
  integer     b;
  integer     i;

  reg         awready_ff;
  reg         wready_ff;
  reg         aw_got_ff;
  reg         w_got_ff;
  reg  [7:0]  awaddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg         arready_ff;
  reg         rvalid_ff;
  reg  [31:0] rdata_ff;
  reg  [1:0]  rresp_ff;

  wire        rise0;
  wire        fall0;
  wire        bad0;
  wire        rise1;
  wire        fall1;
  wire        bad1;
  wire        req_sel;
  wire [7:0]  req_en;
  wire        sel_rise;
  wire        sel_fall;
  wire        sel_bad;
  wire [31:0] status_word;

  // ************************************************************
  // decode: 0 control, 1 status, 2 unmapped
  // ************************************************************
  function [1:0] gcm_dec;
    input [7:0] addr;
    begin
      if (addr == `GCM_CTRL_OFS) begin
        gcm_dec = 2'h0;
      end else if (addr == `GCM_STAT_OFS) begin
        gcm_dec = 2'h1;
      end else begin
        gcm_dec = 2'h2;
      end
    end
  endfunction

  // ************************************************************
  // input monitors
  // ************************************************************
  gcm_clk_monitor u_mon0 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clk_level (first_input_pair),
    .rise      (rise0),
    .fall      (fall0),
    .bad       (bad0)
  );

  gcm_clk_monitor u_mon1 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clk_level (second_input_pair),
    .rise      (rise1),
    .fall      (fall1),
    .bad       (bad1)
  );

  // events of the input currently feeding the banks
  assign sel_rise = cur_sel_ff ? rise1 : rise0; // see RQ17
  assign sel_fall = cur_sel_ff ? fall1 : fall0;
  assign sel_bad  = cur_sel_ff ? bad1 : bad0;

  // requested settings from the control word
  assign req_sel = ctrl_ff[`GCM_CTRL_SEL_BIT];
  assign req_en  = ctrl_ff[`GCM_CTRL_EN_MSB:`GCM_CTRL_EN_LSB];

  // ************************************************************
  // bank dividers, switch sequencer, output gating
  // ************************************************************
  // select and divide changes while running only act on edges of the selected
  // input or on its bad flag, so a stopped input defers them until the flag sets
  always @* begin
    req_ratio   = {ctrl_ff[`GCM_CTRL_RATB_BIT], ctrl_ff[`GCM_CTRL_RATA_BIT]};
    nxt_state   = state_ff;
    nxt_cur_sel = cur_sel_ff;
    nxt_seen    = seen_ff;
    nxt_level   = level_ff;
    nxt_ratio   = ratio_ff;
    nxt_frz     = frz_ff;
    bnd         = 2'b00;
    for (b = 0; b < 2; b = b + 1) begin
      // end of a period: the falling edge of the bank clock
      bnd[b] = level_ff[b] & ((~ratio_ff[b] & sel_fall) |
                              (ratio_ff[b] & sel_rise));
      if (frz_ff[b]) begin
        nxt_level[b] = 1'b0;
        nxt_ratio[b] = req_ratio[b]; // see RQ11
      end else begin
        if (ratio_ff[b]) begin
          if (sel_rise) begin
            nxt_level[b] = ~level_ff[b]; // see RQ18
          end
        end else if (sel_rise) begin
          nxt_level[b] = 1'b1;
        end else if (sel_fall) begin
          nxt_level[b] = 1'b0;
        end
        if (bnd[b]) begin
          nxt_ratio[b] = req_ratio[b]; // see RQ4
        end
        if (state_ff == ST_DRAIN && bnd[b]) begin
          nxt_frz[b] = 1'b1; // see RQ2
        end
      end
    end
    case (state_ff)
      ST_RUN: begin
        if (sel_bad) begin
          nxt_frz   = 2'b11; // see RQ9
          nxt_level = 2'b00;
          nxt_state = ST_HOLD;
          if (req_sel != cur_sel_ff) begin
            nxt_cur_sel = req_sel; // see RQ10
            nxt_seen    = 1'b0;
          end else begin
            nxt_seen    = 1'b1;
          end
        end else if (req_sel != cur_sel_ff) begin
          nxt_state = ST_DRAIN; // see RQ1
        end
      end
      ST_DRAIN: begin
        if (sel_bad || (&nxt_frz)) begin
          nxt_frz     = 2'b11; // see RQ14
          nxt_level   = 2'b00;
          nxt_cur_sel = req_sel; // see RQ15
          nxt_seen    = 1'b0;
          nxt_state   = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (req_sel != cur_sel_ff) begin
          nxt_cur_sel = req_sel;
          nxt_seen    = 1'b0;
        end else if (sel_rise && !sel_bad) begin
          if (seen_ff) begin
            nxt_frz   = 2'b00; // see RQ3
            nxt_level = 2'b11;
            nxt_ratio = req_ratio;
            nxt_state = ST_RUN;
          end else begin
            nxt_seen = 1'b1; // see RQ16
          end
        end
      end
      default: begin
        nxt_state = ST_HOLD;
        nxt_frz   = 2'b11;
        nxt_level = 2'b00;
      end
    endcase
    // per output enable handling
    nxt_oe   = oe_ff;
    nxt_live = live_ff;
    nxt_q    = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      if (req_en[i] && !oe_ff[i]) begin
        nxt_oe[i]   = 1'b1; // see RQ6
        nxt_live[i] = 1'b0; // see RQ13
      end else if (req_en[i] && !live_ff[i]) begin
        if (nxt_level[i/4] && !level_ff[i/4]) begin
          nxt_live[i] = 1'b1;
        end
      end else if (!req_en[i] && oe_ff[i]) begin
        if (frz_ff[i/4] || nxt_frz[i/4] || !live_ff[i]) begin
          nxt_oe[i]   = 1'b0; // see RQ12
          nxt_live[i] = 1'b0;
        end else if (bnd[i/4]) begin
          nxt_oe[i]   = 1'b0; // see RQ5
          nxt_live[i] = 1'b0;
        end
      end
      nxt_q[i] = nxt_level[i/4] & nxt_live[i];
    end
  end

  // sequencer and output flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= ST_HOLD;
      cur_sel_ff <= 1'b0;
      seen_ff    <= 1'b0;
      level_ff   <= 2'b00;
      ratio_ff   <= 2'b00;
      frz_ff     <= 2'b11;
      oe_ff      <= 8'h00;
      live_ff    <= 8'h00;
      q_ff       <= 8'h00;
    end else begin
      state_ff   <= nxt_state;
      cur_sel_ff <= nxt_cur_sel;
      seen_ff    <= nxt_seen;
      level_ff   <= nxt_level;
      ratio_ff   <= nxt_ratio;
      frz_ff     <= nxt_frz;
      oe_ff      <= nxt_oe;
      live_ff    <= nxt_live;
      q_ff       <= nxt_q;
    end
  end

  assign bank_a_clock_outputs = q_ff[3:0];
  assign bank_b_clock_outputs = q_ff[7:4];
  assign bank_a_oe            = oe_ff[3:0];
  assign bank_b_oe            = oe_ff[7:4];

  // ************************************************************
  // register bus slave
  // ************************************************************
  assign status_word = {8'h00, live_ff, oe_ff, 2'b00, state_ff,
                        1'b0, cur_sel_ff, bad1, bad0};

  // write path: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `GCM_RESP_OKAY;
      ctrl_ff    <= `GCM_CTRL_RST; // see RQ19
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_got_ff  <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end else if (!aw_got_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_got_ff  <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end else if (!w_got_ff && !bvalid_ff) begin
        wready_ff <= 1'b1;
      end
      if (aw_got_ff && w_got_ff && !bvalid_ff) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= `GCM_RESP_OKAY;
        if (gcm_dec(awaddr_ff) == 2'h0) begin
          if (wstrb_ff[0]) begin
            ctrl_ff[7:0] <= wdata_ff[7:0];
          end
          if (wstrb_ff[1]) begin
            ctrl_ff[11:8] <= wdata_ff[11:8];
          end
        end else if (gcm_dec(awaddr_ff) == 2'h2) begin
          bresp_ff <= `GCM_RESP_SLVERR;
        end
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read path: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= `GCM_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rresp_ff   <= `GCM_RESP_OKAY;
        if (gcm_dec(s_axi_araddr) == 2'h0) begin
          rdata_ff <= {20'h00000, ctrl_ff};
        end else if (gcm_dec(s_axi_araddr) == 2'h1) begin
          rdata_ff <= status_word;
        end else begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= `GCM_RESP_SLVERR;
        end
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end else if (!rvalid_ff) begin
        arready_ff <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

endmodule // gcm_clock_mux

/* File: rtl/gcm_map.vh */
`ifndef GCM_MAP_VH
`define GCM_MAP_VH

// ************************************************************
// register offsets (byte addresses on the register bus)
// ************************************************************
`define GCM_CTRL_OFS       8'h00
`define GCM_STAT_OFS       8'h04

// ************************************************************
// control word fields
// ************************************************************
`define GCM_CTRL_SEL_BIT   0
`define GCM_CTRL_RATA_BIT  1
`define GCM_CTRL_RATB_BIT  2
`define GCM_CTRL_EN_LSB    4
`define GCM_CTRL_EN_MSB    11
`define GCM_CTRL_RST       12'hFF0

// ************************************************************
// status word fields
// ************************************************************
`define GCM_STAT_BAD0_BIT  0
`define GCM_STAT_BAD1_BIT  1
`define GCM_STAT_CSEL_BIT  2
`define GCM_STAT_ST_LSB    4
`define GCM_STAT_ST_MSB    5
`define GCM_STAT_OE_LSB    8
`define GCM_STAT_OE_MSB    15
`define GCM_STAT_LIVE_LSB  16
`define GCM_STAT_LIVE_MSB  23

// ************************************************************
// bus answers
// ************************************************************
`define GCM_RESP_OKAY      2'h0
`define GCM_RESP_SLVERR    2'h2

// ************************************************************
// timing
// ************************************************************
`define GCM_CLK_NS         20
`define GCM_STUCK_NS       200
`define GCM_STUCK_CYC      ((`GCM_STUCK_NS + `GCM_CLK_NS - 1) / `GCM_CLK_NS)
`define GCM_DEFER_NS       1000
`define GCM_DEFER_CYC      (`GCM_DEFER_NS / `GCM_CLK_NS)
`define GCM_RECOVER_RISES  3'h5

`endif

/* File: tb/gcm_clk_src.sv */
`timescale 1ns/1ps
// ************************************************************
// two reference clock sources
// ************************************************************
module gcm_clk_src #(
  parameter H0 = 60,
  parameter H1 = 100
) (
  input  wire run0,
  input  wire run1,
  output reg  first_input_pair,
  output reg  second_input_pair
);
  // a stopped source freezes at its level, like a dead oscillator
  initial begin
    first_input_pair = 1'b0;
    #7;
    forever begin
      #H0;
      if (run0) first_input_pair = ~first_input_pair;
    end
  end

  // odd offsets keep edges away from the system clock edges
  initial begin
    second_input_pair = 1'b0;
    #13;
    forever begin
      #H1;
      if (run1) second_input_pair = ~second_input_pair;
    end
  end
endmodule // gcm_clk_src

/* File: tb/gcm_clock_mux_assertions.sv */
`timescale 1ns/1ps
// ************************************************************
// port checks of the clock mux
// ************************************************************
module gcm_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        first_input_pair,
  input wire        second_input_pair,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire [3:0]  bank_a_clock_outputs,
  input wire [3:0]  bank_a_oe,
  input wire [3:0]  bank_b_clock_outputs
);
  reg  [1:0] prv_ff;
  reg  [4:0] st0_ff;
  reg  [4:0] st1_ff;
  wire [4:0] nxt_st0;
  wire [4:0] nxt_st1;
  wire [7:0] outs;

  // idle cycles per input, saturating so a dead clock stays flagged
  assign nxt_st0 = (first_input_pair != prv_ff[0]) ? 5'h00 :
                   st0_ff + {4'h0, ~&st0_ff};
  assign nxt_st1 = (second_input_pair != prv_ff[1]) ? 5'h00 :
                   st1_ff + {4'h0, ~&st1_ff};
  assign outs = {bank_b_clock_outputs, bank_a_clock_outputs};

  // idle counters
  always @(posedge aclk) begin
    if (!aresetn) begin
      prv_ff <= 2'h0;
      st0_ff <= 5'h00;
      st1_ff <= 5'h00;
    end else begin
      prv_ff <= {second_input_pair, first_input_pair};
      st0_ff <= nxt_st0;
      st1_ff <= nxt_st1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_ans;
    ##[1:2] s_axi_bvalid;
  endsequence

  a_write_answer: assert property (s_wr_take |-> s_wr_ans)
    else $error("write response late");
  a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  a_oe_rise_low: assert property (
    ~|(bank_a_oe & ~$past(bank_a_oe) & bank_a_clock_outputs))
    else $error("output enabled while high");
  a_oe_fall_low: assert property (
    ~|(~bank_a_oe & $past(bank_a_oe) & bank_a_clock_outputs))
    else $error("output disabled mid period");
  a_high_min: assert property ($rose(bank_a_clock_outputs[0]) |=>
    bank_a_clock_outputs[0]) else $error("short high pulse");
  a_low_min: assert property ($fell(bank_a_clock_outputs[0]) |=>
    !bank_a_clock_outputs[0]) else $error("short low pulse");
  a_bank_b_min: assert property ($rose(bank_b_clock_outputs[0]) |=>
    bank_b_clock_outputs[0]) else $error("short bank b pulse");
  a_stuck_quiet: assert property (st0_ff >= 5'h12 && st1_ff >= 5'h12 |->
    outs == 8'h00) else $error("outputs run with dead inputs");
endmodule // gcm_chk

bind gcm_clock_mux gcm_chk u_chk (.aclk, .aresetn, .first_input_pair,
  .second_input_pair, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .bank_a_clock_outputs, .bank_a_oe, .bank_b_clock_outputs);

/* File: tb/glitchless_clock_mux_divider_tb.sv */
`timescale 1ns/1ps
`include "gcm_map.vh"
// ************************************************************
// test sequence
// ************************************************************
module glitchless_clock_mux_divider_tb;
  localparam [7:0] ctl = `GCM_CTRL_OFS;
  localparam [7:0] sts = `GCM_STAT_OFS;
  localparam [1:0] ok  = `GCM_RESP_OKAY;
  localparam [1:0] se  = `GCM_RESP_SLVERR;
  reg         aclk, aresetn, run0, run1;
  reg  [7:0]  awaddr, araddr, prv_ff;
  reg         awvalid, wvalid, bready, arvalid, rready;
  reg  [31:0] wdata, d;
  wire        c0, c1, awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [3:0]  qa, qb, oea, oeb;
  wire [7:0]  outs = {qb, qa};
  integer     err_count, n_tests;
  integer     cyc = 0;

  gcm_clk_src u_src (.run0(run0), .run1(run1), .first_input_pair(c0),
    .second_input_pair(c1));
  gcm_clock_mux u_dut (.aclk(aclk), .aresetn(aresetn),
    .first_input_pair(c0), .second_input_pair(c1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bank_a_clock_outputs(qa), .bank_a_oe(oea),
    .bank_b_clock_outputs(qb), .bank_b_oe(oeb));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // edge history and hang guard
  always @(posedge aclk) begin
    prv_ff <= outs;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end

  task end_sim;
    begin
      if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] v, input [1:0] er);
    reg aw, w;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      while (!(aw && w)) begin
        @(posedge aclk);
        if (awvalid && awready) begin
          aw = 1'b1;
          awvalid <= 1'b0;
        end
        if (wvalid && wready) begin
          w = 1'b1;
          wvalid <= 1'b0;
        end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      chk(bresp, er);
      bready <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [1:0] er);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      chk(rresp, er);
      rready <= 1'b0;
    end
  endtask

  // waits for a rising edge on one output, bounded
  task rise_at(input integer i);
    integer n;
    begin
      n = 0;
      do begin
        @(posedge aclk);
        #1;
        n = n + 1;
      end while (!(outs[i] === 1'b1 && prv_ff[i] === 1'b0) && n < 400);
    end
  endtask

  // first rise may be a partial period, so it is skipped
  task meas(input integer i, input integer ex);
    time t;
    begin
      rise_at(i);
      rise_at(i);
      t = $time;
      rise_at(i);
      chk((($time - t) / 20), ex);
    end
  endtask

  task idle(input integer n);
    begin
      repeat (n) @(posedge aclk);
    end
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {run0, run1} = 2'h3;
    err_count = 0;
    n_tests = 0;
    idle(5);
    aresetn <= 1'b1;
    rd(ctl, ok);
    chk(d, 32'h0000_0FF0);
    chk({oeb, oea}, 8'hFF);
    rd(8'h08, se);
    chk(d, 32'h0);
    wr(8'h08, 32'h1, se);
    wr(sts, 32'hFFFF_FFFF, ok);
    meas(0, 6);
    wr(ctl, 32'hFF5, ok);
    meas(0, 10);
    meas(4, 20);
    rd(sts, ok);
    chk(d[2], 1'b1);
    wr(ctl, 32'hFD5, ok);
    idle(30);
    chk(oea, 4'hD);
    wr(ctl, 32'hFF5, ok);
    idle(30);
    chk(oea, 4'hF);
    meas(4, 20);
    // bank b back to divide by one while running
    wr(ctl, 32'hFF1, ok);
    meas(4, 10);
    // both sources die
    run0 <= 1'b0;
    run1 <= 1'b0;
    idle(30);
    rd(sts, ok);
    chk(d[1:0], 2'h3);
    chk(outs, 8'h00);
    wr(ctl, 32'hFE5, ok);
    idle(2);
    chk(oea, 4'hE);
    run0 <= 1'b1;
    run1 <= 1'b1;
    idle(25);
    rd(sts, ok);
    chk(d[1], 1'b1);
    idle(40);
    rd(sts, ok);
    chk(d[1:0], 2'h0);
    // output 0 comes back only after its input has recovered
    wr(ctl, 32'hFF5, ok);
    meas(0, 10);
    // selected source dies, move to the live one
    run1 <= 1'b0;
    idle(30);
    wr(ctl, 32'hFF4, ok);
    meas(0, 6);
    run1 <= 1'b1;
    idle(80);
    // switch while the stop is still undetected
    run0 <= 1'b0;
    wr(ctl, 32'hFF5, ok);
    meas(0, 10);
    run0 <= 1'b1;
    // ratio change while the selected input is flagged
    run1 <= 1'b0;
    idle(30);
    wr(ctl, 32'hFF7, ok);
    run1 <= 1'b1;
    meas(0, 20);
    end_sim;
  end
endmodule // glitchless_clock_mux_divider_tb
